// >>> acp_pkg.sv
// Package of shared constants and types for the capacity/power command block
package acp_pkg;
   // Command codes
   localparam logic [7:0] CMD_SET_MAX = 8'hF9;
   localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
   localparam logic [7:0] CMD_SET_MULT = 8'hC6;
   localparam logic [7:0] CMD_SLEEP_A = 8'h99;
   localparam logic [7:0] CMD_SLEEP_B = 8'hE6;
   localparam logic [7:0] CMD_STBY_A = 8'h96;
   localparam logic [7:0] CMD_STBY_B = 8'hE2;
   localparam logic [7:0] CMD_SMART = 8'hB0;
   // Set max subcommands
   localparam logic [7:0] SMX_OBSOLETE = 8'h00;
   localparam logic [7:0] SMX_SET_PWD = 8'h01;
   localparam logic [7:0] SMX_LOCK = 8'h02;
   localparam logic [7:0] SMX_UNLOCK = 8'h03;
   localparam logic [7:0] SMX_FREEZE = 8'h04;
   // Self-monitoring signature
   localparam logic [7:0] SMART_CYL_HI = 8'hC2;
   localparam logic [7:0] SMART_CYL_LO = 8'h4F;
   // Identify word 82 bit 0
   localparam int IDENT_SMART_WORD = 82;
   localparam int IDENT_SMART_BIT = 0;
   // Drive/head and sector count field positions
   localparam int DH_LBA_BIT = 6;
   localparam int DH_DEV_BIT = 4;
   localparam int SC_VV_BIT = 0;
   // Defaults
   localparam logic [27:0] NATIVE_MAX_DEF = 28'h0FFFFFF;
   localparam logic [7:0] MULT_MAX_DEF = 8'h10;
   // Status bits
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_ERR = 0;
   localparam logic [7:0] ERR_ABRT = 8'h04;
   // Host register map (APB byte addresses)
   localparam logic [7:0] HR_CTRL = 8'h00;
   localparam logic [7:0] HR_TF0 = 8'h04;
   localparam logic [7:0] HR_TF1 = 8'h08;
   localparam logic [7:0] HR_STAT = 8'h0C;
   localparam logic [7:0] HR_ISTAT = 8'h10;
   localparam logic [7:0] HR_IMASK = 8'h14;
   localparam logic [7:0] HR_MAX = 8'h18;
   typedef enum logic [1:0] {
      ACP_IDLE = 2'b00,
      ACP_BUSY = 2'b01,
      ACP_DONE = 2'b11
   } acp_state_t;
endpackage

// >>> acp_if.sv
// Task-file link between host controller and device command block
`timescale 1ns/10ps
interface acp_if;
   logic cmd_valid;
   logic [7:0] cmd;
   logic [7:0] features;
   logic [7:0] sec_count;
   logic [7:0] sec_num;
   logic [7:0] cyl_lo;
   logic [7:0] cyl_hi;
   logic [7:0] drv_head;
   logic [7:0] status;
   logic [7:0] error;
   logic [27:0] max_addr;
   logic intrq;
   logic sleeping;
   modport device (input cmd_valid, cmd, features, sec_count, sec_num,
      cyl_lo, cyl_hi, drv_head, output status, error, max_addr, intrq,
      sleeping);
   modport host (output cmd_valid, cmd, features, sec_count, sec_num,
      cyl_lo, cyl_hi, drv_head, input status, error, max_addr, intrq,
      sleeping);
endinterface

// >>> acp_device.sv
// Device end: decodes and executes capacity and power task-file commands
//
// Summary of operation
// - F9h loads max address from task file
// - Host sets address-type bit for LBA
// - Host sets drive-select bit to target
// - Set max needs ready and prior F8h
// - Volatile bit chooses reset-surviving maximum
// - Feature register selects set max subcommand
// - Abort repeat non-volatile set max after reset
// - C6h sets busy, checks sector count
// - Valid block size stored, multiple enabled
// - Unsupported block size aborts, disables multiple
// - Zero block size disables multiple
// - Multiple disabled after power-on
// - 99h/E6h sleep, interrupt immediately
// - 96h/E2h standby, interrupt immediately
// - Any new command wakes device
// - Host loads self-monitoring signature and feature
// - Identify word 82 bit 0 reports support
`timescale 1ns/10ps
module acp_device (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   acp_if.device tf,
   input wire logic [27:0] nv_max_in,
   input wire logic nv_max_valid,
   output logic nv_max_we,
   output logic [27:0] nv_max_out,
   output logic mult_enabled,
   output logic [7:0] mult_count,
   output logic pwd_set,
   output logic max_locked,
   output logic max_frozen,
   output logic smart_req,
   output logic [7:0] smart_sub,
   output logic [15:0] ident_word82,
   input wire logic [7:0] smart_status
);
   // --------------------------------------------------------------
   // Command decode
   // --------------------------------------------------------------
   function automatic logic is_pair(logic [7:0] c, logic [7:0] a,
      logic [7:0] b);
      return (c == a) || (c == b);
   endfunction
   acp_pkg::acp_state_t state_q;
   logic [27:0] max_q;
   logic read_native_q;
   logic nv_set_q;
   logic sleep_q;
   logic err_q;
   logic intrq_q;
   logic loaded_q;
   logic [7:0] cmd_q;
   logic [7:0] feat_q;
   logic [7:0] sc_q;
   logic [7:0] chi_q;
   logic [7:0] clo_q;
   logic [7:0] sn_q;
   logic [7:0] dh_q;
   wire take = clk_en && tf.cmd_valid && state_q == acp_pkg::ACP_IDLE;
   wire c_setmax = cmd_q == acp_pkg::CMD_SET_MAX;
   wire c_native = cmd_q == acp_pkg::CMD_READ_NATIVE;
   wire c_mult = cmd_q == acp_pkg::CMD_SET_MULT;
   wire c_sleep = is_pair(cmd_q, acp_pkg::CMD_SLEEP_A,
      acp_pkg::CMD_SLEEP_B);
   wire c_stby = is_pair(cmd_q, acp_pkg::CMD_STBY_A, acp_pkg::CMD_STBY_B);
   wire c_smart = cmd_q == acp_pkg::CMD_SMART;
   wire vv = sc_q[acp_pkg::SC_VV_BIT];
   wire [27:0] new_max = {dh_q[3:0], chi_q, clo_q, sn_q};
   wire sub_addr = feat_q == acp_pkg::SMX_OBSOLETE;
   wire sub_pwd = feat_q == acp_pkg::SMX_SET_PWD;
   wire sub_lock = feat_q == acp_pkg::SMX_LOCK;
   wire sub_unlk = feat_q == acp_pkg::SMX_UNLOCK;
   wire sub_frz = feat_q == acp_pkg::SMX_FREEZE;
   wire sub_bad = feat_q > acp_pkg::SMX_FREEZE;
   // Ready prerequisite and native read directly before
   wire seq_ok = read_native_q && loaded_q;
   // Second non-volatile set since reset is refused
   wire nv_again = sub_addr && vv && nv_set_q;
   wire lock_blk = max_frozen || (max_locked && !sub_unlk);
   wire sm_abort = !seq_ok || sub_bad || nv_again || lock_blk ||
      (sub_unlk && max_frozen);
   // Supported counts: powers of two up to the default maximum
   wire mult_pow2 = (sc_q & (sc_q - 8'h01)) == 8'h00;
   wire mult_ok = sc_q != 8'h00 && mult_pow2 &&
      sc_q <= acp_pkg::MULT_MAX_DEF;
   wire smart_sig = chi_q == acp_pkg::SMART_CYL_HI &&
      clo_q == acp_pkg::SMART_CYL_LO;
   wire abort = (c_setmax && sm_abort) || (c_mult && sc_q != 8'h00 &&
      !mult_ok) || (c_smart && !smart_sig);
   // --------------------------------------------------------------
   // Capture and sequencing
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= acp_pkg::ACP_IDLE;
         cmd_q <= 8'h00;
         feat_q <= 8'h00;
         sc_q <= 8'h00;
         chi_q <= 8'h00;
         clo_q <= 8'h00;
         sn_q <= 8'h00;
         dh_q <= 8'h00;
      end else if (clk_en) begin
         unique case (state_q)
            acp_pkg::ACP_IDLE: begin
               if (take) begin
                  state_q <= acp_pkg::ACP_BUSY;
                  cmd_q <= tf.cmd;
                  feat_q <= tf.features;
                  sc_q <= tf.sec_count;
                  chi_q <= tf.cyl_hi;
                  clo_q <= tf.cyl_lo;
                  sn_q <= tf.sec_num;
                  dh_q <= tf.drv_head;
               end
            end
            acp_pkg::ACP_BUSY: state_q <= acp_pkg::ACP_DONE;
            acp_pkg::ACP_DONE: state_q <= acp_pkg::ACP_IDLE;
         endcase
      end
   end
   wire exec = clk_en && state_q == acp_pkg::ACP_BUSY;
   // --------------------------------------------------------------
   // Execution
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         max_q <= acp_pkg::NATIVE_MAX_DEF;
         loaded_q <= 1'b0;
         read_native_q <= 1'b0;
         nv_set_q <= 1'b0;
         sleep_q <= 1'b0;
         err_q <= 1'b0;
         intrq_q <= 1'b0;
         mult_enabled <= 1'b0;
         mult_count <= 8'h00;
         pwd_set <= 1'b0;
         max_locked <= 1'b0;
         max_frozen <= 1'b0;
         smart_req <= 1'b0;
         smart_sub <= 8'h00;
         nv_max_we <= 1'b0;
         nv_max_out <= 28'h0000000;
      end else if (clk_en) begin
         smart_req <= 1'b0;
         nv_max_we <= 1'b0;
         // Revert to stored non-volatile maximum once after reset
         if (!loaded_q) begin
            loaded_q <= 1'b1;
         end
         if (!loaded_q && nv_max_valid) begin
            max_q <= nv_max_in;
         end
         if (take) begin
            sleep_q <= 1'b0;
            intrq_q <= 1'b0;
         end
         if (exec) begin
            err_q <= abort;
            intrq_q <= 1'b1;
            read_native_q <= c_native;
            if (c_sleep || c_stby) begin
               sleep_q <= 1'b1;
            end
            if (c_setmax && !sm_abort) begin
               if (sub_addr) begin
                  max_q <= new_max;
                  if (vv) begin
                     nv_set_q <= 1'b1;
                     nv_max_we <= 1'b1;
                     nv_max_out <= new_max;
                  end
               end
               if (sub_pwd) begin
                  pwd_set <= 1'b1;
               end
               if (sub_lock) begin
                  max_locked <= 1'b1;
               end
               if (sub_unlk) begin
                  max_locked <= 1'b0;
               end
               if (sub_frz) begin
                  max_frozen <= 1'b1;
               end
            end
            if (c_mult) begin
               mult_enabled <= mult_ok;
               if (mult_ok) begin
                  mult_count <= sc_q;
               end
            end
            if (c_smart && smart_sig) begin
               smart_req <= 1'b1;
               smart_sub <= feat_q;
            end
         end
      end
   end
   // --------------------------------------------------------------
   // Task-file outputs
   // --------------------------------------------------------------
   assign tf.status = {state_q != acp_pkg::ACP_IDLE, loaded_q, 5'b00000,
      err_q};
   assign tf.error = err_q ? acp_pkg::ERR_ABRT : 8'h00;
   assign tf.max_addr = max_q;
   assign tf.intrq = intrq_q;
   assign tf.sleeping = sleep_q;
   assign ident_word82 = 16'(1) << acp_pkg::IDENT_SMART_BIT;
endmodule

// >>> acp_host.sv
// Host end: APB-driven task-file controller for the command block
`timescale 1ns/10ps
module acp_host (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   acp_if.host tf
);
   // --------------------------------------------------------------
   // Register decode
   // --------------------------------------------------------------
   logic [31:0] tf0_q;
   logic [31:0] tf1_q;
   logic go_q;
   logic [1:0] ist_q;
   logic [1:0] imask_q;
   logic intrq_d1_q;
   wire wr = psel && penable && pwrite && clk_en;
   wire rd_known = paddr == acp_pkg::HR_CTRL || paddr == acp_pkg::HR_TF0 ||
      paddr == acp_pkg::HR_TF1 || paddr == acp_pkg::HR_STAT ||
      paddr == acp_pkg::HR_ISTAT || paddr == acp_pkg::HR_IMASK ||
      paddr == acp_pkg::HR_MAX;
   wire done_ev = tf.intrq && !intrq_d1_q;
   wire [1:0] ev = {done_ev && tf.status[acp_pkg::ST_ERR], done_ev};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_known;
   // Read data is latched in the setup cycle and stands through access
   wire [31:0] rd_mux =
      paddr == acp_pkg::HR_CTRL ? {31'h00000000, go_q} :
      paddr == acp_pkg::HR_TF0 ? tf0_q :
      paddr == acp_pkg::HR_TF1 ? tf1_q :
      paddr == acp_pkg::HR_STAT ? {14'h0000, tf.sleeping, tf.intrq,
         tf.error, tf.status} :
      paddr == acp_pkg::HR_ISTAT ? {30'h00000000, ist_q} :
      paddr == acp_pkg::HR_IMASK ? {30'h00000000, imask_q} :
      paddr == acp_pkg::HR_MAX ? {4'h0, tf.max_addr} : 32'h00000000;
   assign irq = |(ist_q & imask_q);
   // --------------------------------------------------------------
   // Task file drive
   // --------------------------------------------------------------
   // TF0: cmd[7:0] features[15:8] sec_count[23:16] sec_num[31:24]
   // TF1: cyl_lo[7:0] cyl_hi[15:8] drv_head[23:16]
   assign tf.cmd = tf0_q[7:0];
   assign tf.features = tf0_q[15:8];
   assign tf.sec_count = tf0_q[23:16];
   assign tf.sec_num = tf0_q[31:24];
   assign tf.cyl_lo = tf1_q[7:0];
   assign tf.cyl_hi = tf1_q[15:8];
   assign tf.drv_head = tf1_q[23:16];
   assign tf.cmd_valid = go_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tf0_q <= 32'h00000000;
         tf1_q <= 32'h00000000;
         go_q <= 1'b0;
         ist_q <= 2'b00;
         imask_q <= 2'b00;
         intrq_d1_q <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         intrq_d1_q <= tf.intrq;
         if (psel && !penable) begin
            prdata <= rd_mux;
         end
         // Issue is held until the device leaves idle
         if (go_q && tf.status[acp_pkg::ST_BSY]) begin
            go_q <= 1'b0;
         end
         if (wr && paddr == acp_pkg::HR_CTRL && pwdata[0]) begin
            go_q <= 1'b1;
         end
         if (wr && paddr == acp_pkg::HR_TF0) begin
            tf0_q <= pwdata;
         end
         if (wr && paddr == acp_pkg::HR_TF1) begin
            tf1_q <= pwdata;
         end
         if (wr && paddr == acp_pkg::HR_IMASK) begin
            imask_q <= pwdata[1:0];
         end
         ist_q <= (ist_q & ~((wr && paddr == acp_pkg::HR_ISTAT) ?
            pwdata[1:0] : 2'b00)) | ev;
      end
   end
endmodule

// >>> acp_chk.sv
// Checker of the task-file link between the host and device ends
`timescale 1ns/10ps
module acp_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd,
   input wire logic [7:0] features,
   input wire logic [7:0] sec_count,
   input wire logic [7:0] sec_num,
   input wire logic [7:0] cyl_lo,
   input wire logic [7:0] cyl_hi,
   input wire logic [7:0] drv_head,
   input wire logic [7:0] status,
   input wire logic [7:0] error,
   input wire logic [27:0] max_addr,
   input wire logic intrq,
   input wire logic sleeping
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] last_q;
   logic lock_q;
   wire logic busy = status[acp_pkg::ST_BSY];
   wire logic err = status[acp_pkg::ST_ERR];
   wire logic take = clk_en & cmd_valid & ~busy;
   wire logic setmax = take && cmd == acp_pkg::CMD_SET_MAX;
   wire logic mult = take && cmd == acp_pkg::CMD_SET_MULT;
   wire logic mult_ok = sec_count != 8'h00 && sec_count <= 8'h10 &&
      (sec_count & (sec_count - 8'h01)) == 8'h00;
   wire logic sleep_cmd = cmd == acp_pkg::CMD_SLEEP_A ||
      cmd == acp_pkg::CMD_SLEEP_B || cmd == acp_pkg::CMD_STBY_A ||
      cmd == acp_pkg::CMD_STBY_B;
   // Remembers the previous command and any lock seen since reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         last_q <= 8'h00;
         lock_q <= 1'b0;
      end else if (take) begin
         last_q <= cmd;
         lock_q <= lock_q | (cmd == acp_pkg::CMD_SET_MAX &&
            (features == acp_pkg::SMX_LOCK ||
            features == acp_pkg::SMX_FREEZE));
      end
   end
   sequence s_exec;
      busy [*2] ##1 (!busy && intrq);
   endsequence
   sequence s_abort;
      ##3 (err && error == acp_pkg::ERR_ABRT);
   endsequence
   a_busy_done: assert property (take |=> s_exec)
      else $error("busy or completion timing wrong");
   a_sleep_enter: assert property (take && sleep_cmd
      |-> ##3 sleeping)
      else $error("low-power state not entered");
   a_wake_any: assert property (take |=> !sleeping)
      else $error("device stayed asleep after new command");
   a_max_load: assert property (setmax && !lock_q &&
      last_q == acp_pkg::CMD_READ_NATIVE && features == 8'h00 &&
      !sec_count[0] |-> ##3 (!err && max_addr ==
      $past({drv_head[3:0], cyl_hi, cyl_lo, sec_num}, 3)))
      else $error("maximum address not loaded");
   a_max_order: assert property (setmax && last_q != 8'hF8 |->
      s_abort ##0 (max_addr == $past(max_addr, 3)))
      else $error("out of order set max not refused");
   a_sub_rsvd: assert property (setmax && features > 8'h04 |-> s_abort)
      else $error("reserved subcommand accepted");
   a_mult_bad: assert property (mult && !mult_ok && sec_count != 8'h00
      |-> s_abort)
      else $error("unsupported block size accepted");
   a_mult_good: assert property (mult && mult_ok |-> ##3 !err)
      else $error("supported block size refused");
   a_smart_sig: assert property (take && cmd == acp_pkg::CMD_SMART &&
      (cyl_hi != 8'hC2 || cyl_lo != 8'h4F) |-> s_abort)
      else $error("bad signature accepted");
   a_intrq_hold: assert property (intrq && !take |=> intrq)
      else $error("interrupt dropped before next command");
endmodule

// >>> ata_capacity_power_cmds_tb_top.sv
// Bench joining host and device ends, driven over APB
`timescale 1ns/10ps
`define CHK(g, e) check(64'(g), 64'(e))
module ata_capacity_power_cmds_tb_top;
   localparam logic [7:0] SUBS [7] = '{8'h05, 8'h01, 8'h02, 8'h00, 8'h03,
      8'h04, 8'h03};
   localparam logic [7:0] SIZES [6] = '{8'h00, 8'h04, 8'h03, 8'h20, 8'h10,
      8'h01};
   localparam logic [7:0] PWR [4] = '{8'h99, 8'hE6, 8'h96, 8'hE2};
   logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, nv_valid = 1'b0, intrq_q = 1'b0, ok, slv;
   logic [7:0] paddr = 8'h00, s, mult_cnt, smart_sub;
   logic [31:0] pwdata = 32'h0, prdata, rd, r;
   logic pready, pslverr, irq, nv_we, mult_en, pwd_set, locked, frozen;
   logic smart_req, ce = 1'b1;
   logic [27:0] nv_store = 28'h0, nv_out, exp_max, nv_v;
   logic [15:0] ident;
   logic [28:0] exp_q[$];
   int bad_count = 0, tests_run = 0, done_cnt = 0, seed = 23423;
   int smart_cnt = 0;
   acp_if tf();
   always #4 core_clk = ~core_clk;
   acp_host acp_host_i (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .tf(tf));
   acp_device acp_device_i (.core_clk(core_clk), .resetn(resetn),
      .clk_en(ce), .tf(tf), .nv_max_in(nv_store), .nv_max_valid(nv_valid),
      .nv_max_we(nv_we), .nv_max_out(nv_out), .mult_enabled(mult_en),
      .mult_count(mult_cnt), .pwd_set(pwd_set), .max_locked(locked),
      .max_frozen(frozen), .smart_req(smart_req), .smart_sub(smart_sub),
      .ident_word82(ident), .smart_status(8'h00));
   acp_chk acp_chk_i (.core_clk(core_clk), .resetn(resetn), .clk_en(ce),
      .cmd_valid(tf.cmd_valid), .cmd(tf.cmd), .features(tf.features),
      .sec_count(tf.sec_count), .sec_num(tf.sec_num), .cyl_lo(tf.cyl_lo),
      .cyl_hi(tf.cyl_hi), .drv_head(tf.drv_head), .status(tf.status),
      .error(tf.error), .max_addr(tf.max_addr), .intrq(tf.intrq),
      .sleeping(tf.sleeping));
   // ------------------------------------------------------------------
   // Non-volatile store and completion monitor
   // ------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (nv_we === 1'b1) begin
         nv_store <= nv_out;
         nv_valid <= 1'b1;
      end
   end
   always @(negedge core_clk) begin
      intrq_q <= tf.intrq;
      if (smart_req === 1'b1)
         smart_cnt++;
      if (tf.intrq === 1'b1 && intrq_q !== 1'b1) begin
         done_cnt++;
         if (exp_q.size() != 0)
            `CHK({tf.status[0], tf.max_addr}, exp_q.pop_front());
      end
   end
   task automatic check(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Drive/head carries LBA bit set and drive 0 selected
   task automatic cmd(input logic [7:0] c, f, sc, input logic [27:0] a,
      input logic e);
      int n;
      n = done_cnt;
      if (c == acp_pkg::CMD_SET_MAX && f == 8'h00 && !e)
         exp_max = a;
      exp_q.push_back({e, exp_max});
      apb(1'b1, acp_pkg::HR_TF0, {a[7:0], sc, f, c});
      apb(1'b1, acp_pkg::HR_TF1, {8'h00, 4'hE, a[27:24], a[23:16], a[15:8]});
      apb(1'b1, acp_pkg::HR_CTRL, 32'h1);
      repeat (100) if (done_cnt == n) @(posedge core_clk);
      if (done_cnt == n)
         `CHK(done_cnt, n + 1);
   endtask
   task automatic pair(input logic [7:0] f, sc, input logic [27:0] a,
      input logic e);
      cmd(acp_pkg::CMD_READ_NATIVE, 8'h00, 8'h00, 28'h0, 1'b0);
      cmd(acp_pkg::CMD_SET_MAX, f, sc, a, e);
   endtask
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      exp_max = acp_pkg::NATIVE_MAX_DEF;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK({mult_en, ident[0], tf.status[6]}, 3'b011);
      r = $random(seed);
      cmd(acp_pkg::CMD_SET_MAX, 8'h00, 8'h00, r[27:0], 1'b1);
      pair(8'h00, 8'h00, r[27:0], 1'b0);
      nv_v = r[27:0] ^ 28'h5A5A5A5;
      pair(8'h00, 8'h01, nv_v, 1'b0);
      pair(8'h00, 8'h01, r[27:0], 1'b1);
      pair(8'h00, 8'h00, r[27:0], 1'b0);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(negedge core_clk);
      exp_max = nv_v;
      `CHK(tf.max_addr, nv_v);
      for (int i = 0; i < 7; i++)
         pair(SUBS[i], 8'h00, r[27:0], i == 0 || i == 3 || i == 6);
      `CHK({pwd_set, locked, frozen}, 3'b101);
      for (int i = 0; i < 7; i++) begin
         r = $random(seed);
         s = i < 6 ? SIZES[i] : r[7:0];
         ok = s != 8'h00 && s <= 8'h10 && (s & (s - 8'h01)) == 8'h00;
         cmd(acp_pkg::CMD_SET_MULT, 8'h00, s, 28'h0, !ok && s != 8'h00);
         @(negedge core_clk);
         `CHK(mult_en, ok);
         if (ok)
            `CHK(mult_cnt, s);
      end
      foreach (PWR[i]) begin
         cmd(PWR[i], 8'h00, 8'h00, 28'h0, 1'b0);
         @(negedge core_clk);
         `CHK(tf.sleeping, 1'b1);
      end
      // Frozen device leaves a pending command waiting
      @(posedge core_clk);
      ce <= 1'b0;
      exp_q.push_back({1'b0, exp_max});
      apb(1'b1, acp_pkg::HR_TF0, {24'h000000, acp_pkg::CMD_SLEEP_A});
      apb(1'b1, acp_pkg::HR_CTRL, 32'h1);
      repeat (4 + r[2:0]) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({tf.status[7], tf.intrq, tf.sleeping, tf.cmd_valid}, 4'h7);
      @(posedge core_clk);
      ce <= 1'b1;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({tf.status[7], tf.cmd_valid, tf.sleeping}, 3'b001);
      cmd(acp_pkg::CMD_SMART, r[15:8], 8'h00, {12'h0C2, 8'h4F, 8'h00}, 1'b0);
      `CHK({smart_sub, tf.sleeping}, {r[15:8], 1'b0});
      cmd(acp_pkg::CMD_SMART, 8'hD0, 8'h00, {12'h0C2, 8'h4E, 8'h00}, 1'b1);
      apb(1'b1, acp_pkg::HR_ISTAT, 32'h3);
      apb(1'b1, acp_pkg::HR_IMASK, 32'h0);
      cmd(acp_pkg::CMD_SET_MULT, 8'h00, 8'h03, 28'h0, 1'b1);
      apb(1'b0, acp_pkg::HR_STAT, 32'h0);
      `CHK({irq, rd[15:8], rd[0]}, {1'b0, 8'h04, 1'b1});
      apb(1'b0, acp_pkg::HR_ISTAT, 32'h0);
      `CHK(rd[1:0], 2'b11);
      apb(1'b1, acp_pkg::HR_IMASK, 32'h2);
      @(negedge core_clk);
      `CHK(irq, 1'b1);
      apb(1'b1, acp_pkg::HR_ISTAT, 32'h2);
      @(negedge core_clk);
      `CHK(irq, 1'b0);
      apb(1'b0, 8'h1C, 32'h0);
      `CHK({slv, rd}, {1'b1, 32'h0});
      `CHK(exp_q.size(), 0);
      `CHK(smart_cnt, 1);
      finish_test();
   end
   initial begin
      #100000;
      `CHK(1'b1, 1'b0);
      finish_test();
   end
endmodule
